// ---- verilog/pfcst_regs.sv ----
`timescale 1ns/10ps
// Summary of operation
// - Summary byte read returns the low eight bits of the summary word.
// - Every status bit reads 1 when its condition occurred, 0 when absent.
// - Bit 7 is set when the device was busy and could not respond.
// - Bit 6 is set while no power is delivered to the output.
// - Low byte: bit 5 output OV, bit 4 output OC, bit 3 input UV.
// - Bit 2 flags any temperature condition, bit 1 any communication fault.
// - Bit 0 flags an active condition not covered by bits 7 to 1, other than a negated power good.
// - Word bits 15, 14, 13: output voltage, output current, input.
// - Word bit 12 flags manufacturer conditions, bit 11 a negated power good.
// - Word bit 10 flags fan conditions; bit 9 always reads 0.
// - Word bit 8 flags an active condition not covered by bits 15 to 1.
// - Output voltage status: OV fault 7, OV warn 6, UV warn 5, UV fault 4.
// - Input status: input OV fault 7, UV warning 5, UV fault 4.
// - Input status bit 3 is set while off for too low input voltage.
// - Input status: OC fault 2, OC warning 1, overpower warning 0.
// - Temperature status: OT fault 7, OT warning 6, bits 5 to 0 reserved.
// - Input voltage readback exponent in bits 15:11, from exponent 5:3.
// - Input current readback uses the same layout, exponent from bits 10:6.
// - Output voltage readback takes its signed exponent from mode bits 2:0.
// - Readbacks carry mantissa high bits in 10:8 and low byte in 7:0.
module pfcst_regs
(
    // Clock and reset.
    input wire logic clock_in,
    input wire logic rst_in,
    // Command port from the serial interface.
    input wire logic [7:0] cmd_code_in,
    input wire logic rd_req_in,
    input wire logic wr_req_in,
    input wire logic [15:0] wr_data_in,
    input wire logic busy_event_in,
    input wire logic clear_faults_in,
    // Fault and state inputs from the protection logic.
    input wire logic [3:0] vout_flags_in,
    input wire logic [6:0] input_flags_in,
    input wire logic vin_low_in,
    input wire logic [1:0] temp_flags_in,
    input wire logic iout_oc_in,
    input wire logic cml_in,
    input wire logic mfr_in,
    input wire logic fan_in,
    input wire logic unknown_in,
    input wire logic power_off_in,
    input wire logic power_good_in,
    // Measurements and their exponent fields.
    input wire logic meas_valid_in,
    input wire logic [pfcst_pkg::LIN_MANT_W-1:0] vin_mant_in,
    input wire logic [pfcst_pkg::LIN_MANT_W-1:0] iin_mant_in,
    input wire logic [pfcst_pkg::LIN_MANT_W-1:0] vout_mant_in,
    input wire logic [2:0] vin_exp_field_in,
    input wire logic [4:0] iin_exp_field_in,
    input wire logic [2:0] vout_exp_field_in,
    // Read answer and write-ignored flag.
    output logic [15:0] rd_data_out,
    output logic rd_valid_out,
    output logic rd_hit_out,
    output logic wr_ignored_out
);
    import pfcst_pkg::*;

    pfcst_state_t q;
    pfcst_state_t next_q;
    logic [15:0] status_word;
    logic [7:0] input_status;
    logic [7:0] temperature_status;
    logic [7:0] vout_status;

    // The three-bit exponent fields are signed, so they are widened by sign.
    function automatic logic [LIN_EXP_W-1:0] sext3(input logic [2:0] e);
        sext3 = {{(LIN_EXP_W-3){e[2]}}, e};
    endfunction

    function automatic logic [15:0] lin_word(
        input logic [LIN_EXP_W-1:0] e,
        input logic [LIN_MANT_W-1:0] m
    );
        lin_word = {e, m};
    endfunction

    assign vout_status = q.vout_st;
    assign input_status = q.input_st;
    assign temperature_status = q.temp_st;

    // The summary is rebuilt every cycle from the detail and the live power
    // inputs, so it agrees with the detailed registers of the same cycle.
    always_comb
    begin
        status_word = 16'h0000;
        status_word[SW_VOUT] = |vout_status;
        status_word[SW_IOUT] = q.iout_oc;
        status_word[SW_INPUT] = |input_status;
        status_word[SW_MFR] = q.mfr;
        status_word[SW_PGOOD_N] = ~power_good_in;
        status_word[SW_FANS] = q.fan;
        status_word[SW_OTHER] = 1'b0;
        status_word[SW_UNKNOWN] = q.unknown;
        status_word[SW_BUSY] = q.busy;
        status_word[SW_OFF] = power_off_in;
        status_word[SW_VOUT_OV] = vout_status[VS_OV_FAULT];
        status_word[SW_IOUT_OC] = q.iout_oc;
        status_word[SW_VIN_UV] = input_status[IS_VIN_UV_FAULT];
        status_word[SW_TEMP] = |temperature_status;
        status_word[SW_CML] = q.cml;
        status_word[SW_NONE_ABOVE] = q.unknown | q.mfr | q.fan
            | vout_status[VS_OV_WARN] | vout_status[VS_UV_WARN]
            | vout_status[VS_UV_FAULT]
            | (|(input_status & ~(8'h01 << IS_VIN_UV_FAULT)));
    end

    always_comb
    begin
        next_q = q;
        // Sticky flags: a set arriving with a clear wins over the clear.
        next_q.vout_st = (q.vout_st & {8{~clear_faults_in}})
            | {vout_flags_in, 4'h0};
        next_q.input_st = (q.input_st & {8{~clear_faults_in}})
            | {input_flags_in[6], 1'b0, input_flags_in[5:4], 1'b0,
               input_flags_in[2:0]};
        next_q.input_st[IS_VIN_LOW] = vin_low_in;
        next_q.temp_st = (q.temp_st & {8{~clear_faults_in}})
            | {temp_flags_in, 6'h00};
        next_q.iout_oc = (q.iout_oc & ~clear_faults_in) | iout_oc_in;
        next_q.cml = (q.cml & ~clear_faults_in) | cml_in;
        next_q.busy = (q.busy & ~clear_faults_in) | busy_event_in;
        next_q.mfr = (q.mfr & ~clear_faults_in) | mfr_in;
        next_q.fan = (q.fan & ~clear_faults_in) | fan_in;
        next_q.unknown = (q.unknown & ~clear_faults_in) | unknown_in;
        // Measurements are snapshotted so a two-byte read is coherent.
        if (meas_valid_in)
        begin
            next_q.vin_m = vin_mant_in;
            next_q.iin_m = iin_mant_in;
            next_q.vout_m = vout_mant_in;
        end
        next_q.rd_valid = rd_req_in;
        next_q.rd_hit = 1'b0;
        next_q.wr_ignored = wr_req_in & ~rd_req_in;
        if (rd_req_in)
        begin
            next_q.rd_hit = 1'b1;
            case (cmd_code_in)
                CMD_STATUS_BYTE:
                    next_q.rd_data = {8'h00, status_word[7:0]};
                CMD_STATUS_WORD: next_q.rd_data = status_word;
                CMD_VOUT_STATUS: next_q.rd_data = {8'h00, vout_status};
                CMD_INPUT_STATUS: next_q.rd_data = {8'h00, input_status};
                CMD_TEMP_STATUS: next_q.rd_data = {8'h00, temperature_status};
                CMD_VIN_READBACK:
                    next_q.rd_data = lin_word(sext3(vin_exp_field_in),
                        q.vin_m);
                CMD_IIN_READBACK:
                    next_q.rd_data = lin_word(iin_exp_field_in,
                        q.iin_m);
                CMD_VOUT_READBACK:
                    next_q.rd_data = lin_word(sext3(vout_exp_field_in),
                        q.vout_m);
                default:
                begin
                    next_q.rd_data = RD_DATA_RESET;
                    next_q.rd_hit = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            q.vout_st <= STATUS_RESET;
            q.input_st <= STATUS_RESET;
            q.temp_st <= STATUS_RESET;
            q.iout_oc <= 1'b0;
            q.cml <= 1'b0;
            q.busy <= 1'b0;
            q.mfr <= 1'b0;
            q.fan <= 1'b0;
            q.unknown <= 1'b0;
            q.vin_m <= MANT_RESET;
            q.iin_m <= MANT_RESET;
            q.vout_m <= MANT_RESET;
            q.rd_data <= RD_DATA_RESET;
            q.rd_valid <= 1'b0;
            q.rd_hit <= 1'b0;
            q.wr_ignored <= 1'b0;
        end
        else
        begin
            q <= next_q;
        end
    end

    assign rd_data_out = q.rd_data;
    assign rd_valid_out = q.rd_valid;
    assign rd_hit_out = q.rd_hit;
    assign wr_ignored_out = q.wr_ignored;

    // The write data is deliberately discarded; every register here is
    // read-only, so only the fact of the write is reported.
    logic unused_wr;
    assign unused_wr = ^wr_data_in;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    sequence s_read(logic [7:0] code);
        rd_req_in && cmd_code_in == code;
    endsequence

    sequence s_snap_then_read(logic [7:0] code);
        meas_valid_in ##1 (!meas_valid_in && rd_req_in && cmd_code_in == code);
    endsequence

    a_byte_is_low: assert property (
        s_read(CMD_STATUS_BYTE) |=> rd_data_out == {8'h00,
            $past(status_word[7:0])} && rd_valid_out && rd_hit_out)
        else $error("status byte differs from low status word byte");

    a_flag_set_wins: assert property (
        (cml_in && clear_faults_in) |=> status_word[SW_CML])
        else $error("set lost against simultaneous clear");

    a_busy_sticky: assert property (
        busy_event_in ##1 (!clear_faults_in)[*3] |=> status_word[SW_BUSY])
        else $error("busy flag not held until cleared");

    a_off_reported: assert property (
        (s_read(CMD_STATUS_WORD) && power_off_in) |=> rd_data_out[SW_OFF])
        else $error("power off not reported in bit 6");

    a_vout_ov_summary: assert property (
        vout_flags_in[3] |=> status_word[SW_VOUT_OV] && status_word[SW_VOUT])
        else $error("output overvoltage not summarised");

    a_temp_summary: assert property (
        temp_flags_in != 2'b00 |=> status_word[SW_TEMP])
        else $error("temperature condition not summarised");

    a_none_above: assert property (
        (mfr_in || fan_in || unknown_in) |=> status_word[SW_NONE_ABOVE])
        else $error("unlisted condition not flagged in bit 0");

    a_input_summary: assert property (
        (input_flags_in & 7'h77) != 7'h00 |=> status_word[SW_INPUT])
        else $error("input condition not summarised in bit 13");

    a_pgood_negated: assert property (
        (s_read(CMD_STATUS_WORD) && !power_good_in)
            |=> rd_data_out[SW_PGOOD_N])
        else $error("negated power good not reported");

    a_other_zero: assert property (
        s_read(CMD_STATUS_WORD) |=> !rd_data_out[SW_OTHER])
        else $error("status word bit 9 read as one");

    a_unknown_bit: assert property (
        unknown_in |=> status_word[SW_UNKNOWN])
        else $error("unknown condition not flagged in bit 8");

    a_vout_uv_fault: assert property (
        vout_flags_in[0] ##1 s_read(CMD_VOUT_STATUS)
            |=> rd_data_out[VS_UV_FAULT])
        else $error("output undervoltage fault not on bit 4");

    a_input_ov_fault: assert property (
        input_flags_in[6] |=> input_status[IS_VIN_OV_FAULT]
            && !input_status[6])
        else $error("input overvoltage fault not on bit 7");

    a_vin_low_level: assert property (
        !vin_low_in ##1 !vin_low_in |-> !input_status[IS_VIN_LOW])
        else $error("low input flag held after input recovered");

    a_overpower_warn: assert property (
        input_flags_in[0] |=> input_status[IS_PIN_OP_WARN])
        else $error("input overpower warning not on bit 0");

    a_temp_reserved: assert property (
        s_read(CMD_TEMP_STATUS) |=> rd_data_out[5:0] == 6'h00)
        else $error("reserved temperature bits not zero");

    a_vin_readback: assert property (
        s_snap_then_read(CMD_VIN_READBACK) |=> rd_data_out ==
            {sext3($past(vin_exp_field_in)), $past(vin_mant_in, 2)})
        else $error("input voltage readback layout wrong");

    a_iin_exponent: assert property (
        s_read(CMD_IIN_READBACK) |=> rd_data_out[15:11] ==
            $past(iin_exp_field_in))
        else $error("input current exponent wrong");

    a_vout_exponent: assert property (
        s_read(CMD_VOUT_READBACK) |=> rd_data_out[15:11] ==
            sext3($past(vout_exp_field_in)))
        else $error("output voltage exponent wrong");

    a_iin_mantissa: assert property (
        s_snap_then_read(CMD_IIN_READBACK) |=> rd_data_out[10:0] ==
            $past(iin_mant_in, 2))
        else $error("input current mantissa wrong");

    a_write_ignored: assert property (
        (wr_req_in && !rd_req_in && !meas_valid_in) |=> wr_ignored_out
            && !rd_valid_out && $stable(q.vin_m) && $stable(q.iin_m)
            && $stable(q.vout_m))
        else $error("write altered a read-only register");

    a_vout_ov_warn: assert property (
        vout_flags_in[2] |=> vout_status[VS_OV_WARN]
            && status_word[SW_NONE_ABOVE])
        else $error("output overvoltage warning not on bit 6");

    a_vout_uv_warn: assert property (
        vout_flags_in[1] |=> vout_status[VS_UV_WARN])
        else $error("output undervoltage warning not on bit 5");

    a_vin_uv_fault: assert property (
        input_flags_in[4] |=> status_word[SW_VIN_UV]
            && input_status[IS_VIN_UV_FAULT])
        else $error("input undervoltage fault not summarised");

    a_vin_uv_warn: assert property (
        input_flags_in[5] |=> input_status[IS_VIN_UV_WARN])
        else $error("input undervoltage warning not on bit 5");

    a_iin_oc_fault: assert property (
        input_flags_in[2] |=> input_status[IS_IIN_OC_FAULT])
        else $error("input overcurrent fault not on bit 2");

    a_iin_oc_warn: assert property (
        input_flags_in[1] |=> input_status[IS_IIN_OC_WARN])
        else $error("input overcurrent warning not on bit 1");

    a_ot_fault_bit: assert property (
        temp_flags_in[1] |=> temperature_status[TS_OT_FAULT])
        else $error("overtemperature fault not on bit 7");

    a_ot_warn_bit: assert property (
        temp_flags_in[0] |=> temperature_status[TS_OT_WARN])
        else $error("overtemperature warning not on bit 6");

    a_iout_summary: assert property (
        iout_oc_in |=> status_word[SW_IOUT] && status_word[SW_IOUT_OC])
        else $error("output overcurrent not summarised");

    a_cml_bit: assert property (
        cml_in |=> status_word[SW_CML])
        else $error("communication fault not on bit 1");

    a_mfr_bit: assert property (
        mfr_in |=> status_word[SW_MFR])
        else $error("manufacturer condition not on bit 12");

    a_fan_bit: assert property (
        fan_in |=> status_word[SW_FANS])
        else $error("fan condition not on bit 10");

    a_vin_low_set: assert property (
        vin_low_in |=> input_status[IS_VIN_LOW])
        else $error("low input level not on bit 3");

    a_word_read: assert property (
        s_read(CMD_STATUS_WORD) |=> rd_data_out == $past(status_word)
            && rd_hit_out)
        else $error("status word read differs from summary");

endmodule // pfcst_regs

// ---- shared/pfcst_pkg.sv ----
package pfcst_pkg;

    // Command codes of the status and readback registers.
    localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
    localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
    localparam logic [7:0] CMD_VOUT_STATUS = 8'h7a;
    localparam logic [7:0] CMD_INPUT_STATUS = 8'h7c;
    localparam logic [7:0] CMD_TEMP_STATUS = 8'h7d;
    localparam logic [7:0] CMD_VIN_READBACK = 8'h88;
    localparam logic [7:0] CMD_IIN_READBACK = 8'h89;
    localparam logic [7:0] CMD_VOUT_READBACK = 8'h8b;

    // Bit positions of the summary status word.
    localparam int SW_VOUT = 15;
    localparam int SW_IOUT = 14;
    localparam int SW_INPUT = 13;
    localparam int SW_MFR = 12;
    localparam int SW_PGOOD_N = 11;
    localparam int SW_FANS = 10;
    localparam int SW_OTHER = 9;
    localparam int SW_UNKNOWN = 8;
    localparam int SW_BUSY = 7;
    localparam int SW_OFF = 6;
    localparam int SW_VOUT_OV = 5;
    localparam int SW_IOUT_OC = 4;
    localparam int SW_VIN_UV = 3;
    localparam int SW_TEMP = 2;
    localparam int SW_CML = 1;
    localparam int SW_NONE_ABOVE = 0;

    // Bit positions of the output-voltage status register.
    localparam int VS_OV_FAULT = 7;
    localparam int VS_OV_WARN = 6;
    localparam int VS_UV_WARN = 5;
    localparam int VS_UV_FAULT = 4;

    // Bit positions of the input status register.
    localparam int IS_VIN_OV_FAULT = 7;
    localparam int IS_VIN_UV_WARN = 5;
    localparam int IS_VIN_UV_FAULT = 4;
    localparam int IS_VIN_LOW = 3;
    localparam int IS_IIN_OC_FAULT = 2;
    localparam int IS_IIN_OC_WARN = 1;
    localparam int IS_PIN_OP_WARN = 0;

    // Bit positions of the temperature status register.
    localparam int TS_OT_FAULT = 7;
    localparam int TS_OT_WARN = 6;

    // Linear format layout.
    localparam int LIN_EXP_W = 5;
    localparam int LIN_MANT_W = 11;

    // Values after reset.
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [10:0] MANT_RESET = 11'h000;
    localparam logic [15:0] RD_DATA_RESET = 16'h0000;

    typedef struct packed {
        logic [7:0] vout_st;
        logic [7:0] input_st;
        logic [7:0] temp_st;
        logic iout_oc;
        logic cml;
        logic busy;
        logic mfr;
        logic fan;
        logic unknown;
        logic [10:0] vin_m;
        logic [10:0] iin_m;
        logic [10:0] vout_m;
        logic [15:0] rd_data;
        logic rd_valid;
        logic rd_hit;
        logic wr_ignored;
    } pfcst_state_t;

endpackage

// ---- verification/pfcst_host.sv ----
`timescale 1ns/10ps
// Host side of the command port. Between requests the command and data
// lines carry the inverse of their last value, so a block that samples
// them late sees garbage rather than a lucky stale match.
module pfcst_host
(
    // Clock.
    input wire logic clock_in,
    // Requests toward the register block.
    output logic [7:0] cmd_code_out,
    output logic rd_req_out,
    output logic wr_req_out,
    output logic [15:0] wr_data_out,
    // Answers from the register block.
    input wire logic [15:0] rd_data_in,
    input wire logic rd_valid_in,
    input wire logic rd_hit_in,
    input wire logic wr_ignored_in
);
    initial
    begin
        cmd_code_out = 8'h00;
        rd_req_out = 1'b0;
        wr_req_out = 1'b0;
        wr_data_out = 16'h0000;
    end

    task automatic read_reg(input logic [7:0] code, output logic [15:0] data,
        output logic hit, output logic valid);
        @(posedge clock_in);
        cmd_code_out <= code;
        rd_req_out <= 1'b1;
        @(posedge clock_in);
        rd_req_out <= 1'b0;
        cmd_code_out <= ~code;
        #1;
        data = rd_data_in;
        hit = rd_hit_in;
        valid = rd_valid_in;
    endtask

    task automatic write_reg(input logic [7:0] code, input logic [15:0] value,
        output logic ignored);
        @(posedge clock_in);
        cmd_code_out <= code;
        wr_data_out <= value;
        wr_req_out <= 1'b1;
        @(posedge clock_in);
        wr_req_out <= 1'b0;
        cmd_code_out <= ~code;
        wr_data_out <= ~value;
        #1;
        ignored = wr_ignored_in;
    endtask
endmodule // pfcst_host

// ---- verification/test_pfcst_regs.sv ----
`timescale 1ns/10ps
module test_pfcst_regs;
    import pfcst_pkg::*;
    typedef struct packed {
        logic [4:0] idx;
        logic [15:0] word;
        logic [7:0] cmd;
        logic [7:0] sub;
    } pfcst_case_t;
    // One sticky source per entry; flag vector bit 11 is the unused input.
    localparam pfcst_case_t CASES [18] = '{
        '{5'h12, 16'h8020, 8'h7a, 8'h80}, '{5'h11, 16'h8001, 8'h7a, 8'h40},
        '{5'h10, 16'h8001, 8'h7a, 8'h20}, '{5'h0f, 16'h8001, 8'h7a, 8'h10},
        '{5'h0e, 16'h2001, 8'h7c, 8'h80}, '{5'h0d, 16'h2001, 8'h7c, 8'h20},
        '{5'h0c, 16'h2008, 8'h7c, 8'h10}, '{5'h0a, 16'h2001, 8'h7c, 8'h04},
        '{5'h09, 16'h2001, 8'h7c, 8'h02}, '{5'h08, 16'h2001, 8'h7c, 8'h01},
        '{5'h07, 16'h0004, 8'h7d, 8'h80}, '{5'h06, 16'h0004, 8'h7d, 8'h40},
        '{5'h05, 16'h4010, 8'h78, 8'h10}, '{5'h04, 16'h0002, 8'h78, 8'h02},
        '{5'h03, 16'h0080, 8'h78, 8'h80}, '{5'h02, 16'h1001, 8'h78, 8'h01},
        '{5'h01, 16'h0401, 8'h78, 8'h01}, '{5'h00, 16'h0101, 8'h78, 8'h01}};
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] cmd_code;
    logic rd_req, wr_req, rd_valid, rd_hit, wr_ignored;
    logic [15:0] wr_data, rd_data;
    logic [18:0] flags = 19'h00000;
    logic clear_faults = 1'b0;
    logic vin_low = 1'b0;
    logic power_off = 1'b0;
    logic power_good = 1'b1;
    logic meas_valid = 1'b0;
    logic [10:0] vin_m = 11'h5a5;
    logic [10:0] iin_m = 11'h2c3;
    logic [10:0] vout_m = 11'h7ff;
    logic [2:0] vin_e = 3'h5;
    logic [2:0] vout_e = 3'h4;
    logic [4:0] iin_e = 5'h13;
    int mismatches = 0;
    int tests_run = 0;

    always #5 clock_in = ~clock_in;

    pfcst_host u_pfcst_host (.clock_in(clock_in), .cmd_code_out(cmd_code),
        .rd_req_out(rd_req), .wr_req_out(wr_req), .wr_data_out(wr_data),
        .rd_data_in(rd_data), .rd_valid_in(rd_valid), .rd_hit_in(rd_hit),
        .wr_ignored_in(wr_ignored));

    pfcst_regs u_pfcst_regs (.clock_in(clock_in), .rst_in(rst_in),
        .cmd_code_in(cmd_code), .rd_req_in(rd_req), .wr_req_in(wr_req),
        .wr_data_in(wr_data), .busy_event_in(flags[3]),
        .clear_faults_in(clear_faults), .vout_flags_in(flags[18:15]),
        .input_flags_in(flags[14:8]), .vin_low_in(vin_low),
        .temp_flags_in(flags[7:6]), .iout_oc_in(flags[5]), .cml_in(flags[4]),
        .mfr_in(flags[2]), .fan_in(flags[1]), .unknown_in(flags[0]),
        .power_off_in(power_off), .power_good_in(power_good),
        .meas_valid_in(meas_valid), .vin_mant_in(vin_m), .iin_mant_in(iin_m),
        .vout_mant_in(vout_m), .vin_exp_field_in(vin_e),
        .iin_exp_field_in(iin_e), .vout_exp_field_in(vout_e),
        .rd_data_out(rd_data), .rd_valid_out(rd_valid), .rd_hit_out(rd_hit),
        .wr_ignored_out(wr_ignored));

    task automatic chk_val(input string name, input logic [15:0] exp, got);
        tests_run++;
        if (got !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            mismatches++;
        end
    endtask

    task automatic chk_bit(input string name, input logic exp, got);
        tests_run++;
        if (got !== exp)
        begin
            $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
            mismatches++;
        end
    endtask

    task automatic rd_chk(input logic [7:0] code, input logic [15:0] exp,
        input logic exp_hit);
        logic [15:0] d;
        logic h, v;
        u_pfcst_host.read_reg(code, d, h, v);
        chk_val($sformatf("data of %h", code), exp, d);
        chk_bit($sformatf("hit of %h", code), exp_hit, h);
        chk_bit($sformatf("valid of %h", code), 1'b1, v);
    endtask

    // Drives one cycle of flag sources and the clear strobe together.
    task automatic pulse(input logic [18:0] f, input logic clr);
        @(posedge clock_in);
        flags <= f;
        clear_faults <= clr;
        @(posedge clock_in);
        flags <= 19'h00000;
        clear_faults <= 1'b0;
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clock_in);
        mismatches++;
        complete_run();
    end

    initial
    begin
        pfcst_case_t c;
        logic ign;
        repeat (5) @(posedge clock_in);
        rst_in <= 1'b0;
        rd_chk(CMD_STATUS_WORD, 16'h0000, 1'b1);
        rd_chk(8'h7b, 16'h0000, 1'b0);
        $display("test reset and unmapped done");
        for (int i = 0; i < 18; i++)
        begin
            c = CASES[i];
            pulse(19'h00001 << c.idx, 1'b0);
            rd_chk(CMD_STATUS_WORD, c.word, 1'b1);
            rd_chk(CMD_STATUS_BYTE, {8'h00, c.word[7:0]}, 1'b1);
            rd_chk(c.cmd, {8'h00, c.sub}, 1'b1);
            pulse(19'h00000, 1'b1);
            rd_chk(CMD_STATUS_WORD, 16'h0000, 1'b1);
        end
        pulse(19'h00020, 1'b1);
        rd_chk(CMD_STATUS_WORD, 16'h4010, 1'b1);
        pulse(19'h00000, 1'b1);
        $display("test flag sources done");
        power_good <= 1'b0;
        rd_chk(CMD_STATUS_WORD, 16'h0800, 1'b1);
        power_good <= 1'b1;
        power_off <= 1'b1;
        rd_chk(CMD_STATUS_BYTE, 16'h0040, 1'b1);
        power_off <= 1'b0;
        vin_low <= 1'b1;
        rd_chk(CMD_INPUT_STATUS, 16'h0008, 1'b1);
        rd_chk(CMD_STATUS_WORD, 16'h2001, 1'b1);
        vin_low <= 1'b0;
        rd_chk(CMD_INPUT_STATUS, 16'h0000, 1'b1);
        $display("test live levels done");
        @(posedge clock_in);
        meas_valid <= 1'b1;
        @(posedge clock_in);
        meas_valid <= 1'b0;
        vin_m <= 11'h000;
        rd_chk(CMD_VIN_READBACK, {{2{vin_e[2]}}, vin_e, 11'h5a5}, 1'b1);
        rd_chk(CMD_IIN_READBACK, {iin_e, iin_m}, 1'b1);
        rd_chk(CMD_VOUT_READBACK, {2'b11, vout_e, vout_m}, 1'b1);
        vout_e <= 3'h3;
        rd_chk(CMD_VOUT_READBACK, {5'h03, vout_m}, 1'b1);
        $display("test readbacks done");
        u_pfcst_host.write_reg(CMD_STATUS_WORD, 16'hffff, ign);
        chk_bit("write ignored", 1'b1, ign);
        rd_chk(CMD_STATUS_WORD, 16'h0000, 1'b1);
        u_pfcst_host.write_reg(CMD_IIN_READBACK, 16'h0000, ign);
        rd_chk(CMD_IIN_READBACK, {iin_e, iin_m}, 1'b1);
        $display("test writes done");
        complete_run();
    end
endmodule // test_pfcst_regs
